// *** common/sac_map.svh ***
// Purpose: Constants for the SAR converter control block
// Assumes: 40 MHz system clock
// Notes: Encodings of the start selector and input selectors
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_CODE_W 10
`define SAC_DIV_W 5
`define SAC_TRACK_CLKS 4'h3
`define SAC_SAR_BITS 4'hA
`define SAC_NEG_GND 5'h1F
`define SAC_POS_TEMP 5'h1E
`define SAC_POS_VDD 5'h1F
`define SAC_SRC_SW 3'h0
`define SAC_SRC_T0 3'h1
`define SAC_SRC_T2 3'h2
`define SAC_SRC_T1 3'h3
`define SAC_SRC_EXT 3'h4
`define SAC_SRC_T3 3'h5
`define SAC_RES_ZERO 16'h0000
`define SAC_MAX_RATE_KSPS 200
`endif

// *** common/sac_pkg.sv ***
// Purpose: Types for the SAR converter control block
// Assumes: sac_map.svh included first
// Notes: Gray codes along idle, track, convert, done
`default_nettype none
package sac_pkg;
	typedef enum logic [1:0] {
		SAC_IDLE = 2'h0,
		SAC_TRACK = 2'h1,
		SAC_CONV = 2'h3,
		SAC_DONE = 2'h2
	} sac_state_e;
endpackage
`default_nettype wire

// *** hdl/sac_sync.sv ***
// Purpose: Two-stage synchroniser for pin levels
// Assumes: asynchronous active-low reset
// Notes: First stage is read only by the second
`default_nettype none
module sac_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys_i, // System clock
	input wire logic rst_b_i, // Reset, active low
	input wire logic [W-1:0] d_i, // Asynchronous input
	output logic [W-1:0] q_o // Synchronised output
);
	logic [W-1:0] meta_ff;
	// Two flops in series
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_ff <= '0;
			q_o <= '0;
		end else begin
			meta_ff <= d_i;
			q_o <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// *** hdl/sac_ctrl.sv ***
// Purpose: Conversion control for a 10-bit SAR converter
// Assumes: 40 MHz clock, analog core gives one bit per SAR clock
// Notes: Control bits are plain ports; no bus
// Overview of operation
// - Converter runs only while enabled
// - Positive and negative input choices supported
// - Ground negative input means single-ended
// - Single-ended result is 10-bit unsigned
// - Justify bit selects right or left
// - Unused single-ended bits read zero
// - Differential result is two's complement
// - Right-justified differential sign-extends high byte
// - SAR clock is system clock over divider+1
// - Rates up to 200 ksps supported
// - Start source selects the trigger
// - Busy high for whole conversion
// - Busy fall at conversion end sets done flag, interrupt
// - Timer 2/3 overflow byte follows mode
// - Default mode tracks except while converting
// - Low-power mode tracks three SAR clocks
// - External pin low-power: track while low
// - Idle tracking off in standby or sleep
`include "sac_map.svh"
`default_nettype none
module sac_ctrl
	import sac_pkg::*;
#(
	parameter int CODE_W = `SAC_CODE_W,
	parameter int DIV_W = `SAC_DIV_W
) (
	input wire logic clk_sys_i, // System clock
	input wire logic rst_b_i, // Reset, active low
	input wire logic converter_enable_bit_i, // Subsystem enable
	input wire logic left_justify_select_i, // 1 = left-justified
	input wire logic [DIV_W-1:0] sar_clock_divider_i, // Divider field
	input wire logic [2:0] conversion_start_select_i, // Trigger source
	input wire logic low_power_track_select_i, // Low-power tracking
	input wire logic busy_write_one_i, // Software writes one to busy
	input wire logic done_clear_i, // Software clears done flag
	input wire logic done_int_enable_i, // Interrupt enable
	input wire logic [4:0] positive_input_select_i, // Positive mux choice
	input wire logic [4:0] negative_input_select_i, // Negative mux choice
	input wire logic t0_ovf_i, // Timer 0 overflow pulse
	input wire logic t1_ovf_i, // Timer 1 overflow pulse
	input wire logic t2_low_ovf_i, // Timer 2 low-byte overflow
	input wire logic t2_high_ovf_i, // Timer 2 high-byte overflow
	input wire logic t2_split_i, // Timer 2 in 8-bit mode
	input wire logic t3_low_ovf_i, // Timer 3 low-byte overflow
	input wire logic t3_high_ovf_i, // Timer 3 high-byte overflow
	input wire logic t3_split_i, // Timer 3 in 8-bit mode
	input wire logic standby_i, // Device in standby or sleep
	input wire logic external_convert_start_i, // Start pin, asynchronous
	input wire logic comparator_i, // SAR comparator, asynchronous
	output logic conversion_busy_flag_o, // Conversion in progress
	output logic conversion_done_flag_o, // Result valid, sticky
	output logic conversion_irq_o, // Done interrupt request
	output logic [7:0] result_high_byte_o, // Result high byte
	output logic [7:0] result_low_byte_o, // Result low byte
	output logic analog_power_o, // Analog core powered
	output logic track_o, // Track-and-hold tracking
	output logic differential_o, // Differential mode
	output logic [4:0] mux_pos_o, // Positive mux drive
	output logic [4:0] mux_neg_o, // Negative mux drive
	output logic [CODE_W-1:0] dac_trial_o // SAR trial word
);
	localparam int CLK_HZ = 40_000_000;
	localparam int MAX_RATE_SPS = `SAC_MAX_RATE_KSPS * 1000;
	localparam int CYC_PER_SAMPLE = CLK_HZ / MAX_RATE_SPS;

	// Refuse code width, divider width or clock rate the logic cannot serve, at elaboration
	if (CODE_W != `SAC_CODE_W) begin
		$error("CODE_W must match the converter width");
	end
	if (DIV_W < 1 || DIV_W > 8) begin
		$error("DIV_W out of range");
	end
	if (CYC_PER_SAMPLE < 1) begin
		$error("clock too slow");
	end

	typedef struct packed {
		sac_state_e st;
		logic [DIV_W-1:0] div_cnt;
		logic [3:0] step;
		logic [CODE_W-1:0] sar;
		logic [CODE_W-1:0] trial;
		logic busy;
		logic done;
		logic irq;
		logic ext_q;
		logic diff_lat;
		logic [7:0] res_hi;
		logic [7:0] res_lo;
		logic power;
		logic track;
		logic diff;
		logic [4:0] pos;
		logic [4:0] neg;
	} sac_state_s;

	sac_state_s cur_ff;
	sac_state_s nxt_cur;
	logic ext_sync;
	logic cmp_sync;

	// Pin levels cross in through two flops
	sac_sync #(.W(2)) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.d_i({external_convert_start_i, comparator_i}),
		.q_o({ext_sync, cmp_sync})
	);

	logic sar_tick;
	logic ext_rise;
	logic t2_ovf;
	logic t3_ovf;
	logic start_evt;
	logic is_diff;
	logic [15:0] right_word;
	logic [15:0] left_word;
	logic [15:0] res_word;
	logic [CODE_W-1:0] code_fin;
	logic ext_mode;

	// Trigger selection and result formatting
	always_comb begin
		sar_tick = (cur_ff.div_cnt == sar_clock_divider_i);
		ext_rise = ext_sync && !cur_ff.ext_q;
		t2_ovf = t2_split_i ? t2_low_ovf_i : t2_high_ovf_i;
		t3_ovf = t3_split_i ? t3_low_ovf_i : t3_high_ovf_i;
		ext_mode = (conversion_start_select_i == `SAC_SRC_EXT);
		unique case (conversion_start_select_i)
			`SAC_SRC_SW: start_evt = busy_write_one_i;
			`SAC_SRC_T0: start_evt = t0_ovf_i;
			`SAC_SRC_T2: start_evt = t2_ovf;
			`SAC_SRC_T1: start_evt = t1_ovf_i;
			`SAC_SRC_EXT: start_evt = ext_rise;
			`SAC_SRC_T3: start_evt = t3_ovf;
			default: start_evt = 1'b0;
		endcase
		is_diff = (negative_input_select_i != `SAC_NEG_GND);
		// Final bit resolved from the current trial and comparator
		code_fin = cmp_sync ? cur_ff.trial : (cur_ff.trial & ~(cur_ff.trial ^ cur_ff.sar));
		// Sign-extend only in differential mode; zero otherwise
		right_word = {{(16 - CODE_W){cur_ff.diff_lat & code_fin[CODE_W-1]}}, code_fin};
		left_word = {code_fin, {(16 - CODE_W){1'b0}}};
		res_word = left_justify_select_i ? left_word : right_word;
	end

	// Next-state logic of the whole controller
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.ext_q = ext_sync;
		nxt_cur.irq = 1'b0;
		nxt_cur.pos = positive_input_select_i;
		nxt_cur.neg = negative_input_select_i;
		nxt_cur.diff = is_diff;
		nxt_cur.power = converter_enable_bit_i;
		// Clear first, so a same-cycle set wins
		if (done_clear_i) begin
			nxt_cur.done = 1'b0;
		end
		// SAR clock divider runs while a conversion is underway
		if (cur_ff.st == SAC_IDLE || sar_tick) begin
			nxt_cur.div_cnt = '0;
		end else begin
			nxt_cur.div_cnt = cur_ff.div_cnt + 1'b1;
		end
		if (!converter_enable_bit_i) begin
			// Shutdown abandons any conversion in flight
			nxt_cur.st = SAC_IDLE;
			nxt_cur.busy = 1'b0;
			nxt_cur.track = 1'b0;
			nxt_cur.div_cnt = '0;
		end else begin
			unique case (cur_ff.st)
				SAC_IDLE: begin
					// Idle tracking off in standby; else default mode always, low-power only in pin mode with pin low
					if (standby_i) begin
						nxt_cur.track = 1'b0;
					end else if (low_power_track_select_i) begin
						nxt_cur.track = ext_mode && !ext_sync;
					end else begin
						nxt_cur.track = 1'b1;
					end
					if (start_evt) begin
						nxt_cur.busy = 1'b1;
						nxt_cur.done = done_clear_i ? 1'b0 : cur_ff.done;
						nxt_cur.diff_lat = is_diff;
						nxt_cur.step = '0;
						nxt_cur.sar = '0;
						nxt_cur.trial = {1'b1, {(CODE_W - 1){1'b0}}};
						// External pin already tracked while low, so skip the window
						if (low_power_track_select_i && !ext_mode) begin
							nxt_cur.st = SAC_TRACK;
							nxt_cur.track = !standby_i;
						end else begin
							nxt_cur.st = SAC_CONV;
							nxt_cur.track = 1'b0;
						end
					end
				end
				SAC_TRACK: begin
					if (sar_tick) begin
						nxt_cur.step = cur_ff.step + 1'b1;
						if (cur_ff.step == `SAC_TRACK_CLKS - 4'h1) begin
							nxt_cur.st = SAC_CONV;
							nxt_cur.track = 1'b0;
							nxt_cur.step = '0;
						end
					end
				end
				SAC_CONV: begin
					// One bit decided per SAR clock; new starts fall through unused
					nxt_cur.track = 1'b0;
					if (sar_tick) begin
						nxt_cur.step = cur_ff.step + 1'b1;
						if (cmp_sync) begin
							nxt_cur.sar = cur_ff.trial;
						end
						nxt_cur.trial = (cmp_sync ? cur_ff.trial : cur_ff.sar) | (cur_ff.trial ^ cur_ff.sar) >> 1;
						if (cur_ff.step == `SAC_SAR_BITS - 4'h1) begin
							nxt_cur.st = SAC_DONE;
							nxt_cur.res_hi = res_word[15:8];
							nxt_cur.res_lo = res_word[7:0];
						end
					end
				end
				SAC_DONE: begin
					// Busy falls together with the done flag rising
					nxt_cur.busy = 1'b0;
					nxt_cur.done = 1'b1;
					nxt_cur.irq = done_int_enable_i;
					nxt_cur.st = SAC_IDLE;
				end
				default: nxt_cur.st = SAC_IDLE;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cur_ff <= '{st: SAC_IDLE, res_hi: 8'h00, res_lo: 8'h00, default: '0};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// Outputs come straight from the state flops
	assign conversion_busy_flag_o = cur_ff.busy;
	assign conversion_done_flag_o = cur_ff.done;
	assign conversion_irq_o = cur_ff.irq;
	assign result_high_byte_o = cur_ff.res_hi;
	assign result_low_byte_o = cur_ff.res_lo;
	assign analog_power_o = cur_ff.power;
	assign track_o = cur_ff.track;
	assign differential_o = cur_ff.diff;
	assign mux_pos_o = cur_ff.pos;
	assign mux_neg_o = cur_ff.neg;
	assign dac_trial_o = cur_ff.trial;
endmodule
`default_nettype wire

// *** bench/sac_ctrl_assertions.sv ***
// Purpose: Port-level checks for sac_ctrl
// Assumes: divider and selects steady during a conversion
// Notes: bound into every sac_ctrl instance
`include "sac_map.svh"
`default_nettype none
module sac_ctrl_assertions (
	input wire logic clk_sys_i, // Clock
	input wire logic rst_b_i, // Reset
	input wire logic converter_enable_bit_i, // Enable
	input wire logic low_power_track_select_i, // Low-power
	input wire logic [4:0] sar_clock_divider_i, // Divider
	input wire logic [2:0] conversion_start_select_i, // Source
	input wire logic [4:0] negative_input_select_i, // Negative
	input wire logic done_clear_i, // Clear
	input wire logic standby_i, // Standby
	input wire logic track_o, // Tracking
	input wire logic conversion_busy_flag_o, // Busy
	input wire logic conversion_done_flag_o, // Done
	input wire logic conversion_irq_o, // Irq
	input wire logic analog_power_o, // Power
	input wire logic differential_o // Mode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] busy_cnt_ff;
	int unsigned per_bit;
	int unsigned exp_len;
	// Busy length counter; a repetition would be too long to unroll
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_cnt_ff <= 10'h000;
		end else begin
			busy_cnt_ff <= conversion_busy_flag_o ? busy_cnt_ff + 10'h001 : 10'h000;
		end
	end
	// Busy length: ten SAR clocks and the done cycle, plus three of tracking in low-power mode unless the pin starts it
	assign per_bit = 32'(sar_clock_divider_i) + 1;
	assign exp_len = 10 * per_bit + 1 +
		((low_power_track_select_i && conversion_start_select_i != `SAC_SRC_EXT) ? 3 * per_bit : 0);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	a_busy_needs_en: assert property (!converter_enable_bit_i ##1 !converter_enable_bit_i |->
		!conversion_busy_flag_o) else $error("busy while disabled");
	a_power_follows_en: assert property (analog_power_o == $past(converter_enable_bit_i))
		else $error("power does not follow enable");
	a_diff_follows_neg: assert property (differential_o == ($past(negative_input_select_i) != `SAC_NEG_GND))
		else $error("mode does not follow negative input");
	a_done_on_fall: assert property ($fell(conversion_busy_flag_o) && converter_enable_bit_i &&
		$past(converter_enable_bit_i) |-> conversion_done_flag_o) else $error("busy fell without done");
	a_irq_one_cycle: assert property (conversion_irq_o |=> !conversion_irq_o)
		else $error("irq longer than one cycle");
	a_irq_with_done: assert property (conversion_irq_o |-> conversion_done_flag_o && !conversion_busy_flag_o)
		else $error("irq without done");
	a_done_stays_set: assert property (conversion_done_flag_o && !done_clear_i && converter_enable_bit_i |=>
		conversion_done_flag_o) else $error("done dropped without clear");
	a_busy_length: assert property ($fell(conversion_busy_flag_o) && conversion_done_flag_o |->
		busy_cnt_ff == exp_len[9:0]) else $error("wrong conversion length");
	a_track_standby: assert property (standby_i && !conversion_busy_flag_o |=> !track_o)
		else $error("tracking during standby");
	a_hold_in_conv: assert property (conversion_busy_flag_o && !low_power_track_select_i |-> !track_o)
		else $error("tracking during conversion");
endmodule
bind sac_ctrl sac_ctrl_assertions i_chk (.*);
`default_nettype wire

// *** bench/sac_ctrl_test.sv ***
// Purpose: Self-checking bench for sac_ctrl
// Assumes: comparator level steady for a whole conversion
// Notes: results compared in completion order through a queue
`default_nettype none
module sac_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i, rst_b_i, en, lj, lp, bw, clr, ie, t0, t1, t2l, t2h, t2s, t3l, t3h, t3s, ext, cmp, busy, done;
	logic done_q = 1'b0;
	logic sb, trk;
	logic [4:0] dv, pos, neg;
	logic [2:0] sel;
	logic [7:0] rh, rl;
	logic [9:0] code;
	logic [15:0] lfsr = 16'hf15d;
	logic [15:0] exp_q[$];
	int error_cnt, n_tests, cyc;
	sac_ctrl i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .converter_enable_bit_i(en),
		.left_justify_select_i(lj), .sar_clock_divider_i(dv), .conversion_start_select_i(sel),
		.low_power_track_select_i(lp), .busy_write_one_i(bw), .done_clear_i(clr), .done_int_enable_i(ie),
		.positive_input_select_i(pos), .negative_input_select_i(neg), .t0_ovf_i(t0), .t1_ovf_i(t1),
		.t2_low_ovf_i(t2l), .t2_high_ovf_i(t2h), .t2_split_i(t2s), .t3_low_ovf_i(t3l), .t3_high_ovf_i(t3h),
		.t3_split_i(t3s), .standby_i(sb), .external_convert_start_i(ext), .comparator_i(cmp),
		.conversion_busy_flag_o(busy), .conversion_done_flag_o(done), .conversion_irq_o(),
		.result_high_byte_o(rh), .result_low_byte_o(rl), .analog_power_o(), .track_o(trk),
		.differential_o(), .mux_pos_o(), .mux_neg_o(), .dac_trial_o());
	// 40 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	function automatic logic [15:0] step(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One-cycle trigger pulse; the pin stays high so only its rise counts
	task automatic pulse(input int k);
		@(negedge clk_sys_i);
		case (k)
			0: bw = 1'b1;
			1: t0 = 1'b1;
			2: t2l = 1'b1;
			3: t1 = 1'b1;
			4: ext = 1'b1;
			5: t3l = 1'b1;
			6: t2h = 1'b1;
			default: t3h = 1'b1;
		endcase
		@(negedge clk_sys_i);
		{bw, t0, t1, t2l, t2h, t3l, t3h} = '0;
	endtask
	// Each rising done takes the oldest expected word; also the run watchdog
	always @(negedge clk_sys_i) begin
		if (done === 1'b1 && done_q === 1'b0) begin
			if (exp_q.size() == 0)
				check("spare done", 16'h0001, 16'h0000);
			else
				check("result", {rh, rl}, exp_q.pop_front());
		end
		done_q <= done;
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// Every source, justification, tracking mode and input mode in turn
	initial begin
		{en, lj, lp, bw, clr, ie, t0, t1, t2l, t2h, t2s, t3l, t3h, t3s, ext, cmp, sb} = '0;
		{dv, pos, sel} = '0;
		neg = 5'h1f;
		rst_b_i = 1'b0;
		repeat (5) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		@(negedge clk_sys_i);
		en = 1'b1;
		for (int i = 0; i < 48; i++) begin
			lfsr = step(lfsr);
			sel = 3'(i % 6);
			lj = 1'((i / 6) % 2);
			lp = 1'((i / 12) % 2);
			neg = (i < 24) ? 5'h1f : {1'b0, lfsr[3:0]};
			dv = {3'h0, lfsr[9:8]} + 5'h02;
			{cmp, ie, t2s, t3s} = lfsr[15:12];
			pos = lfsr[4:0];
			ext = 1'b0;
			clr = 1'b1;
			@(negedge clk_sys_i);
			clr = 1'b0;
			code = {10{cmp}};
			exp_q.push_back(lj ? {code, 6'h00} : {{6{neg != 5'h1f && cmp}}, code});
			if (sel == 3'h2 || sel == 3'h5) begin
				pulse(sel == 3'h2 ? (t2s ? 6 : 2) : (t3s ? 7 : 5));
				repeat (4) @(negedge clk_sys_i);
				check("busy on unused byte", {15'h0000, busy}, 16'h0000);
				pulse(sel == 3'h2 ? (t2s ? 2 : 6) : (t3s ? 5 : 7));
			end else begin
				pulse(int'(sel));
			end
			repeat (6) @(negedge clk_sys_i);
			pulse(0);
			pulse(1);
			for (int n = 0; n < 600 && done !== 1'b1; n++)
				@(negedge clk_sys_i);
			check("busy after done", {15'h0000, busy}, 16'h0000);
			// Idle tracking: default mode always, low-power never, as the pin is high or not the start source
			@(negedge clk_sys_i);
			check("track idle", {15'h0000, trk}, {15'h0000, !lp});
		end
		// Standby switches idle tracking off
		lp = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		check("track default", {15'h0000, trk}, 16'h0001);
		sb = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		check("track standby", {15'h0000, trk}, 16'h0000);
		sb = 1'b0;
		// Disable in mid-conversion aborts without a result
		clr = 1'b1;
		sel = 3'h0;
		@(negedge clk_sys_i);
		clr = 1'b0;
		pulse(0);
		repeat (8) @(negedge clk_sys_i);
		en = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		check("busy when disabled", {15'h0000, busy}, 16'h0000);
		check("done when disabled", {15'h0000, done}, 16'h0000);
		en = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		// Every note has been taken by a finished conversion; none is left behind
		check("pending results", 16'(exp_q.size()), 16'h0000);
		print_verdict();
	end
endmodule
`default_nettype wire
